/* File: adcc_pkg.sv */
/*
 * Shared constants and types for the converter control and result block.
 * Assumes a 32-bit classic Wishbone register bus with word-aligned offsets.
 */
package adcc_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL_A = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B = 8'h04;
    localparam logic [7:0] ADDR_RES_LO = 8'h08;
    localparam logic [7:0] ADDR_RES_HI = 8'h0c;
    localparam logic [7:0] ADDR_STAT   = 8'h10;
    localparam logic [7:0] ADDR_MASK   = 8'h14;

    // Field positions in conv_ctrl_a and conv_ctrl_b, and the done bit of status and mask
    localparam int START_BIT   = 7;
    localparam int BUSY_BIT    = 6;
    localparam int EN_BIT      = 5;
    localparam int ALIGN_BIT   = 4;
    localparam int GAIN_LO_BIT = 3;
    localparam int GAIN_HI_BIT = 5;
    localparam int DONE_BIT    = 0;

    // Values after reset
    localparam logic [7:0] CTRL_A_RST = 8'h00;
    localparam logic [7:0] CTRL_B_RST = 8'h00;

    // Source select codes
    localparam logic [1:0] SRC_EXT  = 2'h0;
    localparam logic [1:0] SRC_PROX = 2'h1;
    localparam logic [1:0] SRC_BAT  = 2'h2;
    localparam logic [1:0] SRC_SUP  = 2'h3;

    // Gain reference voltage level codes driven out
    localparam logic [1:0] VR_1V6 = 2'h0;
    localparam logic [1:0] VR_3V0 = 2'h1;
    localparam logic [1:0] VR_4V0 = 2'h2;

    // Converter clock counts per phase and per bit, and the result width
    localparam int SAMPLE_CLKS_DEF = 4;
    localparam int BIT_CLKS_DEF    = 4;
    localparam int RES_W           = 10;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONV   = 2'b11,
        ST_FINISH = 2'b10
    } adcc_phase_t;

    typedef struct packed {
        logic [7:0]       ctrl_a;
        logic [7:0]       ctrl_b;
        logic [RES_W-1:0] result;
        logic             done_stat;
        logic             done_mask;
        logic [6:0]       pre;
        adcc_phase_t      phase;
        logic [7:0]       cnt;
        logic [3:0]       bit_idx;
        logic [RES_W-1:0] sar;
        logic [2:0]       cmp_sync;
        logic             cmp_val;
        logic             ack;
        logic [31:0]      dat;
        logic             irq;
        logic             power;
        logic [3:0]       ext_sel;
        logic [2:0]       int_sel;
        logic [1:0]       vref;
        logic             hold;
        logic [RES_W-1:0] dac;
        logic [3:0]       pin_ana;
    } adcc_state_t;

endpackage

/* File: adcc_ctrl.sv */
/*
 * Control, sequencing and result registers of a 10-bit successive
 * approximation converter, with a classic Wishbone slave and one
 * level interrupt.
 * Assumes the analog front end outside: an input mux steered by the
 * select outputs, a sample switch, a 10-bit DAC fed by dac_code_o and a
 * comparator whose output arrives asynchronously on cmp_i.
 */
// Summary of operation
// RULE_01: Result is an unsigned ten-bit value.
// RULE_02: Pick four pins or three internal sources.
// RULE_03: Exactly one input reaches the converter; the code routes none for channel codes 100..111 with source code 00 (pin).
// RULE_04: Left format: high D9..D2, low D1..D0.
// RULE_05: Right format: high D9..D8, low D7..D0.
// RULE_06: Unused result bits read as zero.
// RULE_07: Disabled converter keeps both result bytes.
// RULE_08: Start written high then low launches.
// RULE_09: Busy set on launch, cleared at completion.
// RULE_10: Enable bit powers the converter.
// RULE_11: Gain code selects 1.6, 3.0, 4.0 V.
// RULE_12: Channel codes 000..011 pick pins 0..3.
// RULE_13: Analog pin loses digital function, pull-high.
// RULE_14: Source code picks pin, amp, battery, supply.
// RULE_15: Channel codes 100..111 connect no pin.
// RULE_16: Completion raises the interrupt request flag.
// RULE_17: Converter clock is system clock over 2^code.
// RULE_18: Duration parameterised; result stored before busy clears.

module adcc_ctrl #(
    parameter int SAMPLE_CLKS = adcc_pkg::SAMPLE_CLKS_DEF,
    parameter int BIT_CLKS    = adcc_pkg::BIT_CLKS_DEF
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    input  wire logic        cmp_i,
    input  wire logic [3:0]  pin_adc_cfg_i,
    output logic             conv_power_enable_o,
    output logic      [3:0]  analog_input_pins_sel_o,
    output logic      [2:0]  int_src_sel_o,
    output logic      [1:0]  gain_ref_voltage_o,
    output logic             sample_hold_o,
    output logic      [9:0]  dac_code_o,
    output logic      [3:0]  pin_analog_o
);
    import adcc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Converter clock tick: low code bits of the prescaler all ones
    function automatic logic tick_due(input logic [6:0] pre, input logic [2:0] code);
        logic [6:0] m;
        m = 7'h7f >> (3'h7 - code);
        return (pre & m) == m;
    endfunction

    // Two-bit gain code to reference level
    function automatic logic [1:0] gain_decode(input logic [1:0] code);
        logic [1:0] v;
        case (code)
            2'h1:    v = VR_3V0;
            2'h2:    v = VR_4V0;
            default: v = VR_1V6;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    adcc_state_t q;
    adcc_state_t n;
    logic        busy;
    logic        acc;
    logic        wr;
    logic        launch;
    logic        tick;
    logic [1:0]  src;
    logic [2:0]  chan;
    logic [7:0]  rd_byte;
    logic [9:0]  res_d;

    assign busy = (q.phase != ST_IDLE);
    assign acc  = wb_cyc_i && wb_stb_i && !q.ack;
    assign wr   = acc && wb_we_i && wb_sel_i[0];
    assign src  = q.ctrl_b[7:6];
    assign chan = q.ctrl_a[2:0];
    assign tick = tick_due(q.pre, q.ctrl_b[2:0]); // RULE_17

    ////////////////////////////////////////////////////////////////////////
    // Next state

    // Register bus, sequencer and routing all computed into one copy
    always_comb
    begin
        n      = q;
        launch = 1'b0;

        // Readback formatted at read time, so a format change applies at once
        rd_byte = 8'h00;
        case (wb_adr_i)
            ADDR_CTRL_A: rd_byte = {q.ctrl_a[7], busy, q.ctrl_a[5:0]}; // RULE_09
            ADDR_CTRL_B: rd_byte = q.ctrl_b;
            ADDR_RES_LO: rd_byte = q.ctrl_a[ALIGN_BIT] ? q.result[7:0]
                                 : {q.result[1:0], 6'h00}; // RULE_04 RULE_05 RULE_06
            ADDR_RES_HI: rd_byte = q.ctrl_a[ALIGN_BIT] ? {6'h00, q.result[9:8]}
                                 : q.result[9:2]; // RULE_04 RULE_05 RULE_06
            ADDR_STAT:   rd_byte = {7'h00, q.done_stat};
            ADDR_MASK:   rd_byte = {7'h00, q.done_mask};
            default:     rd_byte = 8'h00; // Unmapped reads as zero
        endcase
        n.ack = acc;
        n.dat = (acc && !wb_we_i) ? {24'h000000, rd_byte} : 32'h00000000;

        // Register writes; busy bit of ctrl_a is not writable
        if (wr)
        begin
            case (wb_adr_i)
                ADDR_CTRL_A:
                begin
                    n.ctrl_a = {wb_dat_i[7], 1'b0, wb_dat_i[5:0]};
                    // Falling start with power on launches from idle
                    launch = q.ctrl_a[START_BIT] && !wb_dat_i[START_BIT]
                             && wb_dat_i[EN_BIT] && !busy; // RULE_08
                end
                ADDR_CTRL_B: n.ctrl_b = wb_dat_i[7:0];
                ADDR_STAT:
                begin
                    if (wb_dat_i[DONE_BIT])
                    begin
                        n.done_stat = 1'b0;
                    end
                end
                ADDR_MASK: n.done_mask = wb_dat_i[DONE_BIT];
                default: ; // Unmapped writes are dropped
            endcase
        end

        // Free-running prescaler feeding the converter clock
        n.pre = q.pre + 7'h01; // RULE_17

        // Comparator crossing: a change counts once stages two and three agree
        n.cmp_sync = {q.cmp_sync[1:0], cmp_i};
        if (q.cmp_sync[2] == q.cmp_sync[1])
        begin
            n.cmp_val = q.cmp_sync[2];
        end

        // Conversion sequencer, one step per converter clock tick while sampling and converting
        case (q.phase)
            ST_IDLE:
            begin
                n.hold = 1'b0;
                if (launch)
                begin
                    n.phase   = ST_SAMPLE; // RULE_09
                    n.cnt     = 8'h00;
                    n.sar     = 10'h000;
                    n.bit_idx = 4'h9;
                    n.hold    = 1'b1;
                end
            end
            ST_SAMPLE:
            begin
                if (tick)
                begin
                    if (q.cnt == 8'(SAMPLE_CLKS - 1)) // RULE_18
                    begin
                        n.phase = ST_CONV;
                        n.cnt   = 8'h00;
                        n.hold  = 1'b0;
                    end
                    else
                    begin
                        n.cnt = q.cnt + 8'h01;
                    end
                end
            end
            ST_CONV:
            begin
                if (tick)
                begin
                    if (q.cnt == 8'(BIT_CLKS - 1)) // RULE_18
                    begin
                        n.cnt = 8'h00;
                        // Comparator high means input at or above trial; take the value
                        // settling at this edge, as the comparator path is four clocks
                        // deep and the registered copy would still show the last trial.
                        // Limitation: BIT_CLKS below 4 is too short at divide code 000.
                        n.sar[q.bit_idx] = n.cmp_val; // RULE_01
                        if (q.bit_idx == 4'h0)
                        begin
                            n.phase = ST_FINISH;
                        end
                        else
                        begin
                            n.bit_idx = q.bit_idx - 4'h1;
                        end
                    end
                    else
                    begin
                        n.cnt = q.cnt + 8'h01;
                    end
                end
            end
            ST_FINISH:
            begin
                // Result lands on the same edge that busy drops
                n.result    = q.sar; // RULE_18 RULE_01
                n.done_stat = 1'b1; // RULE_16
                n.phase     = ST_IDLE; // RULE_09
            end
            default: n.phase = ST_IDLE;
        endcase

        // Power-off aborts and leaves the result bytes untouched
        if (!n.ctrl_a[EN_BIT])
        begin
            n.phase     = ST_IDLE;
            n.hold      = 1'b0;
            n.result    = q.result; // RULE_07
            n.done_stat = (q.done_stat && !(wr && wb_adr_i == ADDR_STAT && wb_dat_i[DONE_BIT]));
        end

        // Trial code for the DAC: kept bits plus the bit under test
        n.dac = (n.phase == ST_CONV) ? (n.sar | 10'(10'h001 << n.bit_idx)) : 10'h000;

        n.irq   = n.done_stat && n.done_mask; // RULE_16
        n.power = q.ctrl_a[EN_BIT]; // RULE_10

        // Internal sources override pins so two never short together
        n.ext_sel = 4'h0;
        if (src == SRC_EXT && !chan[2]) // RULE_15
        begin
            n.ext_sel = 4'(4'h1 << chan[1:0]); // RULE_12 RULE_02 RULE_03
        end
        case (src)
            SRC_PROX: n.int_sel = 3'h1; // RULE_14
            SRC_BAT:  n.int_sel = 3'h2; // RULE_14
            SRC_SUP:  n.int_sel = 3'h4; // RULE_14
            default:  n.int_sel = 3'h0; // RULE_03
        endcase

        n.vref    = gain_decode({q.ctrl_b[GAIN_HI_BIT], q.ctrl_a[GAIN_LO_BIT]}); // RULE_11
        n.pin_ana = pin_adc_cfg_i; // RULE_13

        if (rst_i)
        begin
            n        = '0;
            n.ctrl_a = CTRL_A_RST;
            n.ctrl_b = CTRL_B_RST;
        end
    end

    // Single state register
    always_ff @(posedge clk_i)
    begin
        q <= n;
    end

    // Result as of the previous edge, read by checks only
    always_ff @(posedge clk_i)
    begin
        res_d <= q.result;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state register

    assign wb_dat_o                = q.dat;
    assign wb_ack_o                = q.ack;
    assign irq_o                   = q.irq;
    assign conv_power_enable_o     = q.power;
    assign analog_input_pins_sel_o = q.ext_sel;
    assign int_src_sel_o           = q.int_sel;
    assign gain_ref_voltage_o      = q.vref;
    assign sample_hold_o           = q.hold;
    assign dac_code_o              = q.dac;
    assign pin_analog_o            = q.pin_ana;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    launch_busy_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
        $rose(busy) |-> $past(q.ctrl_a[START_BIT]) && !q.ctrl_a[START_BIT])
        else $error("busy rose without a start high-low sequence");

    busy_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_09
        launch |=> busy ##1 busy)
        else $error("busy not set after launch");

    finish_order_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_18
        (q.phase == ST_FINISH && q.ctrl_a[EN_BIT])
        |=> !busy && q.done_stat && q.result == $past(q.sar))
        else $error("result not stored before busy cleared");

    result_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_07
        !q.ctrl_a[EN_BIT] |=> q.result == $past(q.result))
        else $error("result changed while converter disabled");

    single_route_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
        $onehot0({q.ext_sel, q.int_sel}))
        else $error("more than one input routed");

    float_chan_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_15
        (chan[2] || src != SRC_EXT) |=> q.ext_sel == 4'h0)
        else $error("pin connected for absent channel");

    chan_one_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_12
        (src == SRC_EXT && chan == 3'h1) |=> q.ext_sel == 4'h2)
        else $error("channel code 001 not routed to pin 1");

    src_bat_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_14
        (src == SRC_BAT) |=> q.int_sel == 3'h2 ##1 q.int_sel == 3'h2 || src != SRC_BAT)
        else $error("battery source not routed");

    gain_map_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_11
        ({q.ctrl_b[GAIN_HI_BIT], q.ctrl_a[GAIN_LO_BIT]} == 2'h2) |=> q.vref == VR_4V0)
        else $error("gain code 10 not 4.0 V");

    align_left_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
        (acc && !wb_we_i && wb_adr_i == ADDR_RES_HI && !q.ctrl_a[ALIGN_BIT])
        |=> wb_ack_o && wb_dat_o == {24'h000000, res_d[9:2]})
        else $error("left-aligned high byte wrong");

    align_right_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_05
        (acc && !wb_we_i && wb_adr_i == ADDR_RES_HI && q.ctrl_a[ALIGN_BIT])
        |=> wb_dat_o == {30'h00000000, res_d[9:8]})
        else $error("right-aligned high byte wrong");

    unused_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_06
        (acc && !wb_we_i && wb_adr_i == ADDR_RES_LO && !q.ctrl_a[ALIGN_BIT])
        |=> wb_dat_o == {24'h000000, res_d[1:0], 6'h00})
        else $error("unused low bits not zero");

    power_follow_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_10
        q.ctrl_a[EN_BIT] != conv_power_enable_o |=> conv_power_enable_o == $past(q.ctrl_a[EN_BIT]))
        else $error("power output does not follow enable");

    irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_16
        (q.phase == ST_FINISH && q.ctrl_a[EN_BIT] && q.done_mask) |=> irq_o)
        else $error("completion did not raise interrupt");

    pin_cfg_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_13
        pin_analog_o == $past(pin_adc_cfg_i))
        else $error("pin analog mode not applied");

    // Further decodes, the power-off state and the first trial code
    align_right_lo_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_05
        (acc && !wb_we_i && wb_adr_i == ADDR_RES_LO && q.ctrl_a[ALIGN_BIT])
        |=> wb_dat_o == {24'h000000, res_d[7:0]})
        else $error("right-aligned low byte wrong");

    chan_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_12
        (src == SRC_EXT && chan == 3'h0) |=> q.ext_sel == 4'h1)
        else $error("channel code 000 not routed to pin 0");

    src_prox_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_14
        (src == SRC_PROX) |=> q.int_sel == 3'h1)
        else $error("amplifier source not routed");

    gain_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_11
        ({q.ctrl_b[GAIN_HI_BIT], q.ctrl_a[GAIN_LO_BIT]} == 2'h3) |=> q.vref == VR_1V6)
        else $error("gain code 11 not 1.6 V");

    off_idle_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_10
        !q.ctrl_a[EN_BIT] |-> !busy && !sample_hold_o)
        else $error("converter active while switched off");

    trial_msb_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
        (q.phase == ST_SAMPLE && n.phase == ST_CONV) |=> dac_code_o == 10'h200)
        else $error("first trial is not the top bit");

endmodule

/* File: adcc_analog_model.sv */
/*
 * Behavioural far side of the converter: four pin levels, three internal
 * levels, the sample switch and the comparator.
 * Assumes the select outputs are one-hot and that levels are given as
 * 10-bit codes against full scale.
 */
module adcc_analog_model (
    input  wire logic        clk_i,
    input  wire logic [3:0]  pin_sel_i,
    input  wire logic [2:0]  int_sel_i,
    input  wire logic        sample_i,
    input  wire logic [9:0]  dac_i,
    input  wire logic [39:0] pin_lvl_i,
    input  wire logic [29:0] int_lvl_i,
    output logic             cmp_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [9:0] held  = 10'h000;
    logic [9:0] drift = 10'h000;
    logic [9:0] pick;

    ////////////////////////////////////////////////////////////////////////
    // Input mux; with nothing selected the node floats, so it wanders
    always_comb
    begin
        pick = drift;
        for (int k = 0; k < 4; k++)
            if (pin_sel_i[k]) pick = pin_lvl_i[k*10 +: 10];
        for (int k = 0; k < 3; k++)
            if (int_sel_i[k]) pick = int_lvl_i[k*10 +: 10];
    end

    // Sample switch tracks the input while closed, then holds it
    always @(posedge clk_i)
    begin
        drift <= drift + 10'h155;
        if (sample_i) held <= pick;
    end

    // Comparator is high while the held level reaches the trial code
    assign cmp_o = (held >= dac_i);
endmodule

/* File: tb_top.sv */
/*
 * Self-checking bench for the converter control block: Wishbone master,
 * analog model, random levels and selections, corner cases.
 * Assumes the default phase lengths of the design package.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import adcc_pkg::*;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, cmp;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, wb_dat_o, r;
    logic        wb_ack_o, irq_o, pwr, hold;
    logic [3:0]  pin_cfg = 4'h0, pins, pin_ana;
    logic [2:0]  isel;
    logic [1:0]  vref;
    logic [9:0]  dac, last_v;
    logic [39:0] pin_lvl = 40'h0;
    logic [29:0] int_lvl = 30'h0;
    logic [63:0] r64;
    int          err_total = 0, checks_done = 0, cycles = 0, seed = 57392, dur;

    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            err_total++;
            report_and_stop();
        end
    end

    adcc_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .irq_o(irq_o), .cmp_i(cmp), .pin_adc_cfg_i(pin_cfg), .conv_power_enable_o(pwr),
        .analog_input_pins_sel_o(pins), .int_src_sel_o(isel), .gain_ref_voltage_o(vref),
        .sample_hold_o(hold), .dac_code_o(dac), .pin_analog_o(pin_ana));
    adcc_analog_model far (.clk_i(clk_i), .pin_sel_i(pins), .int_sel_i(isel), .sample_i(hold),
        .dac_i(dac), .pin_lvl_i(pin_lvl), .int_lvl_i(int_lvl), .cmp_o(cmp));

    ////////////////////////////////////////////////////////////////////////
    // Bus cycles: ack is sampled at the rising edge, before the slave updates
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h0, d};
        // No assumed latency: only the bench timeout ends this wait
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            err_total++;
        end
    endtask

    function automatic logic [31:0] fmt(logic [9:0] v, logic al, logic hi);
        if (hi) return al ? {30'h0, v[9:8]} : {24'h0, v[9:2]};
        return al ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h00};
    endfunction

    function automatic logic [31:0] gain_v(logic [1:0] g);
        return (g == 2'h1) ? VR_3V0 : (g == 2'h2) ? VR_4V0 : VR_1V6;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // One full conversion with routing, timing, result and event checks
    task automatic convert(input logic [1:0] s, input logic [2:0] ch, input logic al,
                           input logic [1:0] g, input logic [2:0] ck, input logic m);
        logic [7:0] a;
        int t0;
        a = {3'b001, al, g[0], ch};
        r64 = {$random(seed), $random(seed)};
        @(posedge clk_i);
        pin_lvl <= r64[39:0];
        int_lvl <= r64[63:34];
        last_v = (s != SRC_EXT) ? r64[34 + (s - 1) * 10 +: 10] : r64[ch[1:0] * 10 +: 10];
        xfer(1'b1, ADDR_MASK, {7'h0, m});
        xfer(1'b1, ADDR_CTRL_B, {s, g[1], 2'b00, ck});
        xfer(1'b1, ADDR_CTRL_A, a | 8'h80);
        xfer(1'b1, ADDR_CTRL_A, a);
        t0 = cycles;
        xfer(1'b0, ADDR_CTRL_A, 8'h00);
        chk("ctrl_busy", {24'h0, a | 8'h40}, r);
        chk("vref", gain_v(g), vref);
        chk("pin_sel", (s == SRC_EXT && ch < 4) ? 4'h1 << ch : 4'h0, pins);
        chk("int_sel", (s == SRC_EXT) ? 3'h0 : 3'h1 << (s - 1), isel);
        do xfer(1'b0, ADDR_CTRL_A, 8'h00); while (r[BUSY_BIT] !== 1'b0 && cycles - t0 < 3000);
        // First tick may come one clock after launch, so one tick less is the floor
        chk("duration", 1, (cycles - t0 >= ((SAMPLE_CLKS_DEF + RES_W * BIT_CLKS_DEF - 1) << ck))
            && (cycles - t0 <= ((SAMPLE_CLKS_DEF + RES_W * BIT_CLKS_DEF + 2) << ck) + 16));
        xfer(1'b0, ADDR_STAT, 8'h00);
        chk("done", 32'h1, r);
        chk("irq", m, irq_o);
        xfer(1'b1, ADDR_STAT, 8'h01);
        xfer(1'b0, ADDR_STAT, 8'h00);
        chk("done_clr", 32'h0, r);
        if (s != SRC_EXT || ch < 4)
        begin
            xfer(1'b0, ADDR_RES_HI, 8'h00);
            chk("res_hi", fmt(last_v, al, 1'b1), r);
            xfer(1'b0, ADDR_RES_LO, 8'h00);
            chk("res_lo", fmt(last_v, al, 1'b0), r);
        end
    endtask

    task automatic report_and_stop();
        $display("checks_done %0d err_total %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        xfer(1'b0, ADDR_CTRL_A, 8'h00);
        chk("ctrl_a_rst", {24'h0, CTRL_A_RST}, r);
        xfer(1'b0, ADDR_CTRL_B, 8'h00);
        chk("ctrl_b_rst", {24'h0, CTRL_B_RST}, r);
        xfer(1'b1, 8'h20, 8'hff);
        xfer(1'b0, 8'h20, 8'h00);
        chk("unmapped", 32'h0, r);
        // Every channel code, every source, every gain code, then random mixes
        for (int i = 0; i < 20; i++)
        begin
            r64 = {$random(seed), $random(seed)};
            if (i < 8) convert(SRC_EXT, i[2:0], i[0], i[2:1], i % 4, r64[0]);
            else if (i < 11) convert(i - 7, 3'h4, i[0], i[1:0], 3'h0, r64[0]);
            else convert(r64[1:0], r64[4:2], r64[5], r64[7:6], r64[9:8], r64[10]);
        end
        // Start written high only, then power-off abort keeps the result
        convert(SRC_PROX, 3'h4, 1'b0, 2'h0, 3'h0, 1'b1);
        xfer(1'b1, ADDR_CTRL_A, 8'ha0);
        xfer(1'b0, ADDR_CTRL_A, 8'h00);
        chk("start_held", 32'ha0, r);
        xfer(1'b1, ADDR_CTRL_A, 8'h20);
        xfer(1'b0, ADDR_CTRL_A, 8'h00);
        chk("launched", 32'h60, r);
        chk("power_on", 1'b1, pwr);
        xfer(1'b1, ADDR_CTRL_A, 8'h00);
        xfer(1'b0, ADDR_CTRL_A, 8'h00);
        chk("aborted", 32'h0, r);
        chk("power_off", 1'b0, pwr);
        repeat (100) @(posedge clk_i);
        xfer(1'b0, ADDR_RES_HI, 8'h00);
        chk("kept_hi", fmt(last_v, 1'b0, 1'b1), r);
        xfer(1'b0, ADDR_STAT, 8'h00);
        chk("no_done", 32'h0, r);
        xfer(1'b1, ADDR_CTRL_A, 8'h80);
        xfer(1'b1, ADDR_CTRL_A, 8'h00);
        xfer(1'b0, ADDR_CTRL_A, 8'h00);
        chk("start_disabled", 32'h0, r);
        // Pin analog mode follows configuration one clock later
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk_i);
            pin_cfg <= $random(seed);
            @(posedge clk_i);
            @(negedge clk_i);
            chk("pin_analog", pin_cfg, pin_ana);
        end
        report_and_stop();
    end
endmodule
